// ==== design/lmch_cmd_handler.v ====
// Purpose: decode command packets and drive display, fan and power state
// Assumes: packet framing done outside; one packet presented per cmd_valid_i pulse
// Notes:   answers are one-cycle pulses; saved state except the glyph memory is exposed as plain outputs
`timescale 1ns/1ps
`include "lmch_defs.vh"
module lmch_cmd_handler #(
   parameter HOST_RST_CYC = `LMCH_MS_CYCLES(`LMCH_HOST_RST_MS),
   parameter MUTE_CYC     = `LMCH_MS_CYCLES(`LMCH_MUTE_MS),
   parameter FAN_DLY_CYC  = `LMCH_MS_CYCLES(`LMCH_FAN_DELAY_MS),
   parameter EIGHTH_CYC   = `LMCH_MS_CYCLES(`LMCH_EIGHTH_MS)
) (
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        srst_i,
   // command packet in
   input  wire        cmd_valid_i,
   input  wire [7:0]  cmd_type_i,
   input  wire [4:0]  cmd_len_i,
   input  wire [71:0] cmd_data_i,
   output wire        cmd_ready_o,
   // response packet out
   output reg         rsp_valid_o,
   output reg  [7:0]  rsp_type_o,
   output reg  [3:0]  rsp_len_o,
   output reg  [71:0] rsp_data_o,
   // power supply control
   input  wire [31:0] power_pulse_cyc_i,
   output reg         host_reset_o,
   output reg         host_power_o,
   output reg         self_reboot_o,
   // display state
   output reg  [4:0]  cursor_col_o,
   output reg  [1:0]  cursor_row_o,
   output reg  [1:0]  cursor_style_o,
   output reg  [7:0]  contrast_o,
   output reg  [7:0]  lcd_backlight_o,
   output reg  [7:0]  key_backlight_o,
   output wire [7:0]  cell_o,
   input  wire [6:0]  cell_idx_i,
   // fans
   output wire [31:0] fan_power_o,
   output reg  [3:0]  fan_report_mask_o,
   output wire        fan_report_o,
   output wire [1:0]  fan_report_idx_o
);
   // states
   localparam ST_RUN   = 5'b00001;
   localparam ST_HRST  = 5'b00010;
   localparam ST_HPWR  = 5'b00100;
   localparam ST_MUTE  = 5'b01000;
   localparam ST_BOOT  = 5'b10000;

   reg  [4:0]  state_reg;
   reg  [7:0]  cell_reg [0:`LMCH_CELLS-1];  // display_char_memory
   reg  [7:0]  glyph_reg [0:63];            // glyph_pattern_memory
   reg  [7:0]  fan_lvl_reg [0:3];
   reg         fans_on_reg;
   reg         clearing_reg;
   reg  [6:0]  clr_idx_reg;
   reg         tmr_load;
   reg  [31:0] tmr_count;
   wire        tmr_done;
   reg  [31:0] eighth_cnt_reg;
   wire        eighth_tick;
   wire [3:0]  force_full;
   reg  [31:0] boot_cnt_reg;
   wire [5:0]  op = cmd_type_i[5:0];
   wire [7:0]  d0 = cmd_data_i[7:0];
   wire [7:0]  d1 = cmd_data_i[15:8];
   wire [7:0]  d2 = cmd_data_i[23:16];
   wire [7:0]  d3 = cmd_data_i[31:24];
   // memory read address decode: glyph block or one of four row windows
   wire        mem_glyph = (d0[7:6] == 2'b01);
   wire        mem_cell  = d0[7] && (d0[4:0] <= 5'h13);
   wire [6:0]  cell_base = ({5'h0, d0[6:5]} * 7'd20) + {2'h0, d0[4:0]};
   wire        go = cmd_valid_i && cmd_ready_o;
   integer     i;

   // commands are ignored while resetting the host or muted after reboot
   assign cmd_ready_o = (state_reg == ST_RUN) && !clearing_reg;
   assign cell_o      = cell_reg[cell_idx_i];

   // per-fan output level, forced to full while reported, zero until one cycle before the fan delay ends
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : fan_g
         assign fan_power_o[8*g+7:8*g] = !fans_on_reg ? 8'h0 :
            (force_full[g] ? `LMCH_LEVEL_MAX : fan_lvl_reg[g]);
      end
   endgenerate

   // eighth-second enable pulse
   assign eighth_tick = (eighth_cnt_reg == EIGHTH_CYC - 1);
   always @(posedge ref_clk_i) begin
      if (srst_i || eighth_tick) begin
         eighth_cnt_reg <= 32'h0;
      end else begin
         eighth_cnt_reg <= eighth_cnt_reg + 32'h1;
      end
   end

   lmch_fan_sched u_sched (
      .ref_clk_i    (ref_clk_i),
      .srst_i       (srst_i),
      .tick_i       (eighth_tick),
      .mask_i       (fan_report_mask_o),
      .force_full_o (force_full),
      .report_o     (fan_report_o),
      .report_fan_o (fan_report_idx_o)
   );

   // one shared timer paces host reset, power pulse and mute; only its done pulse is used
   lmch_timer u_tmr (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .load_i    (tmr_load),
      .count_i   (tmr_count),
      .busy_o    (),
      .done_o    (tmr_done)
   );

   // main command decode, answer and state machine
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_reg         <= ST_BOOT;
         rsp_valid_o       <= 1'b0;
         rsp_type_o        <= 8'h0;
         rsp_len_o         <= 4'h0;
         rsp_data_o        <= 72'h0;
         host_reset_o      <= 1'b0;
         host_power_o      <= 1'b0;
         self_reboot_o     <= 1'b0;
         cursor_col_o      <= 5'h0;
         cursor_row_o      <= 2'h0;
         cursor_style_o    <= 2'h0;
         contrast_o        <= 8'h0;
         lcd_backlight_o   <= 8'h0;
         key_backlight_o   <= 8'h0;
         fan_report_mask_o <= 4'h0;
         fans_on_reg       <= 1'b0;
         boot_cnt_reg      <= 32'h0;
         clearing_reg      <= 1'b1;
         clr_idx_reg       <= 7'h0;
         tmr_load          <= 1'b0;
         tmr_count         <= 32'h0;
         for (i = 0; i < 4; i = i + 1) begin
            fan_lvl_reg[i] <= `LMCH_LEVEL_MAX;
         end
      end else begin
         rsp_valid_o   <= 1'b0;
         self_reboot_o <= 1'b0;
         tmr_load      <= 1'b0;
         // fans switch on strictly before the boot delay ends
         if (!fans_on_reg) begin
            boot_cnt_reg <= boot_cnt_reg + 32'h1;
            fans_on_reg  <= (boot_cnt_reg >= FAN_DLY_CYC - 2);
         end
         // background screen fill, one cell per cycle
         if (clearing_reg) begin
            cell_reg[clr_idx_reg] <= `LMCH_BLANK;
            clr_idx_reg           <= clr_idx_reg + 7'h1;
            clearing_reg          <= (clr_idx_reg != `LMCH_CELLS - 1);
         end
         case (state_reg)
            ST_BOOT: begin
               state_reg <= ST_RUN;
            end
            ST_HRST: begin
               if (tmr_done) begin
                  host_reset_o  <= 1'b0;
                  host_power_o  <= 1'b0;
                  self_reboot_o <= 1'b1;
                  tmr_load      <= 1'b1;
                  tmr_count     <= MUTE_CYC;
                  state_reg     <= ST_MUTE;
               end
            end
            ST_MUTE: begin
               if (tmr_done) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (go) begin
                  rsp_valid_o <= 1'b1;
                  rsp_type_o  <= `LMCH_ACK_BIT | {2'b00, op};
                  rsp_len_o   <= 4'h0;
                  rsp_data_o  <= 72'h0;
                  case (op)
                     `LMCH_CMD_RESTART: begin
                        if (cmd_len_i == 5'd3 && d0 == 8'd8 && d1 == 8'd18 && d2 == 8'd99) begin
                           self_reboot_o <= 1'b1;
                        end else if (cmd_len_i == 5'd3 && d0 == 8'd12 && d1 == 8'd28 && d2 == 8'd97) begin
                           host_reset_o <= 1'b1;
                           tmr_load     <= 1'b1;
                           tmr_count    <= HOST_RST_CYC;
                           state_reg    <= ST_HRST;
                        end else if (cmd_len_i == 5'd3 && d0 == 8'd3 && d1 == 8'd11 && d2 == 8'd95) begin
                           host_power_o <= 1'b1;
                           tmr_load     <= 1'b1;
                           tmr_count    <= (power_pulse_cyc_i == 32'h0) ? 32'h1 : power_pulse_cyc_i;
                           state_reg    <= ST_HRST;
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_CLEAR: begin
                        clearing_reg <= 1'b1;
                        clr_idx_reg  <= 7'h0;
                        cursor_col_o <= 5'h0;
                        cursor_row_o <= 2'h0;
                     end
                     `LMCH_CMD_GLYPH: begin
                        if (cmd_len_i == 5'd9 && d0 < 8'd8) begin
                           for (i = 0; i < 8; i = i + 1) begin
                              glyph_reg[{d0[2:0], i[2:0]}] <= {2'b00, cmd_data_i[8*i+13 -: 6]};
                           end
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_MEMRD: begin
                        if (mem_glyph || mem_cell) begin
                           rsp_len_o <= 4'h9;
                           rsp_data_o[7:0] <= d0;
                           for (i = 0; i < 8; i = i + 1) begin
                              rsp_data_o[8*i+8 +: 8] <= mem_glyph ? glyph_reg[(d0[5:0] + i[5:0]) & 6'h3f] :
                                 ((d0[4:0] + i[4:0] <= 5'h13) ? cell_reg[cell_base + i[6:0]] : 8'h0);
                           end
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_CURPOS: begin
                        if (d0 < `LMCH_COLS && d1 < 8'd4) begin
                           cursor_col_o <= d0[4:0];
                           cursor_row_o <= d1[1:0];
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_CURSTY: begin
                        if (d0 < 8'd4) begin
                           cursor_style_o <= d0[1:0];
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_CONTRAST: begin
                        if (d0 <= `LMCH_CONTRAST_MAX) begin
                           contrast_o <= d0;
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_BACKLIGHT: begin
                        if (cmd_len_i == 5'd1 && d0 <= `LMCH_LEVEL_MAX) begin
                           lcd_backlight_o <= d0;
                           key_backlight_o <= d0;
                        end else if (cmd_len_i == 5'd2 && d0 <= `LMCH_LEVEL_MAX && d1 <= `LMCH_LEVEL_MAX) begin
                           lcd_backlight_o <= d0;
                           key_backlight_o <= d1;
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_FANREP: begin
                        if (d0 < 8'h10) begin
                           fan_report_mask_o <= d0[3:0];
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     `LMCH_CMD_FANPWR: begin
                        if (cmd_len_i == 5'd4 && d0 <= `LMCH_LEVEL_MAX && d1 <= `LMCH_LEVEL_MAX &&
                            d2 <= `LMCH_LEVEL_MAX && d3 <= `LMCH_LEVEL_MAX) begin
                           fan_lvl_reg[0] <= d0;
                           fan_lvl_reg[1] <= d1;
                           fan_lvl_reg[2] <= d2;
                           fan_lvl_reg[3] <= d3;
                        end else begin
                           rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                        end
                     end
                     default: begin
                        rsp_type_o <= `LMCH_ERR_BIT | {2'b00, op};
                     end
                  endcase
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end
endmodule // lmch_cmd_handler

// ==== design/lmch_defs.vh ====
// Purpose: constants for the display module command handler
// Assumes: 200 MHz ref_clk_i
// Notes:   times are in ms; cycle counts derived from them
`ifndef LMCH_DEFS_VH
`define LMCH_DEFS_VH
`define LMCH_CMD_RESTART   6'h05
`define LMCH_CMD_CLEAR     6'h06
`define LMCH_CMD_GLYPH     6'h09
`define LMCH_CMD_MEMRD     6'h0a
`define LMCH_CMD_CURPOS    6'h0b
`define LMCH_CMD_CURSTY    6'h0c
`define LMCH_CMD_CONTRAST  6'h0d
`define LMCH_CMD_BACKLIGHT 6'h0e
`define LMCH_CMD_FANREP    6'h10
`define LMCH_CMD_FANPWR    6'h11
`define LMCH_ACK_BIT       8'h40
`define LMCH_ERR_BIT       8'hc0
`define LMCH_BLANK         8'h20
`define LMCH_LEVEL_MAX     8'h64
`define LMCH_CONTRAST_MAX  8'hfe
`define LMCH_COLS          20
`define LMCH_CELLS         80
`define LMCH_CLK_MHZ       200
`define LMCH_FAN_DELAY_MS  500
`define LMCH_HOST_RST_MS   1500
`define LMCH_MUTE_MS       3000
`define LMCH_EIGHTH_MS     125
`define LMCH_MS_CYCLES(ms) ((ms) * `LMCH_CLK_MHZ * 1000)
`endif

// ==== design/lmch_fan_sched.v ====
// Purpose: fan report slot timer and full-power override
// Assumes: tick_i pulses once per eighth second
// Notes:   four slots per half second, one per fan
`timescale 1ns/1ps
module lmch_fan_sched (
   // clock and reset
   input  wire       ref_clk_i,
   input  wire       srst_i,
   // control
   input  wire       tick_i,
   input  wire [3:0] mask_i,
   // results
   output reg  [3:0] force_full_o,
   output reg        report_o,
   output reg  [1:0] report_fan_o
);
   reg [1:0] slot_reg;

   // slot walk: each fan owns one eighth-second slot of every half second
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         slot_reg     <= 2'h0;
         force_full_o <= 4'h0;
         report_o     <= 1'b0;
         report_fan_o <= 2'h0;
      end else begin
         report_o <= 1'b0;
         if (tick_i) begin
            slot_reg     <= slot_reg + 2'h1;
            force_full_o <= mask_i & (4'h1 << slot_reg);
            report_o     <= mask_i[slot_reg];
            report_fan_o <= slot_reg;
         end
      end
   end
endmodule // lmch_fan_sched

// ==== design/lmch_timer.v ====
// Purpose: loadable down counter for long waits
// Assumes: load and count never coincide usefully; load wins
// Notes:   done_o pulses for one cycle at expiry
`timescale 1ns/1ps
module lmch_timer (
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        srst_i,
   // control
   input  wire        load_i,
   input  wire [31:0] count_i,
   // status
   output wire        busy_o,
   output reg         done_o
);
   reg [31:0] cnt_reg;

   // count down to zero and flag the last step
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_reg <= 32'h0;
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i) begin
            cnt_reg <= count_i;
         end else if (cnt_reg != 32'h0) begin
            cnt_reg <= cnt_reg - 32'h1;
            done_o  <= (cnt_reg == 32'h1);
         end
      end
   end
   assign busy_o = (cnt_reg != 32'h0);
endmodule // lmch_timer

// ==== tb/lmch_cmd_handler_chk.sv ====
// Purpose: port-level assertions for the command handler
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to every handler instance by bind
`timescale 1ns/1ps
module lmch_cmd_handler_chk (
   // clock and reset
   input wire        ref_clk_i,
   input wire        srst_i,
   // command and response
   input wire        cmd_valid_i,
   input wire [7:0]  cmd_type_i,
   input wire [4:0]  cmd_len_i,
   input wire [71:0] cmd_data_i,
   input wire        cmd_ready_o,
   input wire        rsp_valid_o,
   input wire [7:0]  rsp_type_o,
   input wire [3:0]  rsp_len_o,
   // state
   input wire        host_reset_o,
   input wire [4:0]  cursor_col_o,
   input wire [1:0]  cursor_row_o,
   input wire [7:0]  contrast_o,
   input wire [7:0]  lcd_backlight_o,
   input wire [7:0]  key_backlight_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // packet taken and its first two bytes
   wire       tk = cmd_valid_i && cmd_ready_o;
   wire [7:0] b0 = cmd_data_i[7:0];
   wire [7:0] b1 = cmd_data_i[15:8];
   chk_rsp_follows: assert property (
      tk |=> rsp_valid_o) else $error("no answer after command");
   chk_rsp_cause: assert property (
      rsp_valid_o |-> $past(tk)) else $error("answer without command");
   chk_type_echo: assert property (
      tk |=> rsp_type_o[5:0] == $past(cmd_type_i[5:0]) && rsp_type_o[6])
      else $error("answer type does not echo command");
   chk_restart_ack: assert property (
      tk && cmd_type_i == 8'h05 && cmd_len_i == 5'd3 && cmd_data_i[23:0] == 24'h611c0c
      |=> rsp_type_o == 8'h45 && rsp_len_o == 4'h0 && host_reset_o)
      else $error("host reset option not acknowledged");
   chk_reset_mute: assert property (
      $rose(host_reset_o) |-> !cmd_ready_o [*8]) else $error("ready during host reset");
   chk_curpos_set: assert property (
      tk && cmd_type_i == 8'h0b && cmd_len_i == 5'd2 && b0 < 8'd20 && b1 < 8'd4
      |=> cursor_col_o == $past(b0[4:0]) && cursor_row_o == $past(b1[1:0]))
      else $error("cursor not placed");
   chk_curpos_bad: assert property (
      tk && cmd_type_i == 8'h0b && cmd_len_i == 5'd2 && b0 > 8'd19
      |=> rsp_type_o == 8'hcb && $stable(cursor_col_o)) else $error("bad column accepted");
   chk_memrd_bad: assert property (
      tk && cmd_type_i == 8'h0a && cmd_len_i == 5'd1 && (b0 < 8'h40 || (b0[7] && b0[4:0] > 5'd19))
      |=> rsp_type_o == 8'hca && rsp_len_o == 4'h0) else $error("bad read address accepted");
   chk_light_both: assert property (
      tk && cmd_type_i == 8'h0e && cmd_len_i == 5'd1 && b0 <= 8'd100
      |=> lcd_backlight_o == $past(b0) && key_backlight_o == $past(b0))
      else $error("backlights not both set");
   chk_contrast_set: assert property (
      tk && cmd_type_i == 8'h0d && cmd_len_i == 5'd1 && b0 < 8'hff
      |=> contrast_o == $past(b0) && rsp_type_o == 8'h4d) else $error("contrast not applied");
endmodule // lmch_cmd_handler_chk
bind lmch_cmd_handler lmch_cmd_handler_chk i_chk (.ref_clk_i, .srst_i, .cmd_valid_i, .cmd_type_i,
   .cmd_len_i, .cmd_data_i, .cmd_ready_o, .rsp_valid_o, .rsp_type_o, .rsp_len_o, .host_reset_o,
   .cursor_col_o, .cursor_row_o, .contrast_o, .lcd_backlight_o, .key_backlight_o);

// ==== tb/lmch_cmd_handler_tb_top.sv ====
// Purpose: self-checking bench for the command handler
// Assumes: shortened wait parameters 50, 50, 20, 16
// Notes:   packets go through the host model
`timescale 1ns/1ps
module lmch_cmd_handler_tb_top;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [31:0] power_pulse_cyc_i = 32'd10;
   logic [6:0] cell_idx_i = 7'd0;
   wire cmd_valid_i, cmd_ready_o, rsp_valid_o, host_reset_o, host_power_o, self_reboot_o, fan_report_o;
   wire [7:0] cmd_type_i, rsp_type_o, contrast_o, lcd_backlight_o, key_backlight_o, cell_o;
   wire [4:0] cmd_len_i, cursor_col_o;
   wire [3:0] rsp_len_o, fan_report_mask_o;
   wire [71:0] cmd_data_i, rsp_data_o;
   wire [1:0] cursor_row_o, cursor_style_o, fan_report_idx_o;
   wire [31:0] fan_power_o;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [7:0] bad_a[6] = '{8'h3f, 8'h94, 8'hb4, 8'hd4, 8'hf4, 8'h00};
   logic [7:0] good_a[6] = '{8'h7f, 8'h93, 8'hb3, 8'hd3, 8'hf3, 8'hc0};
   lmch_cmd_handler #(.HOST_RST_CYC(50), .MUTE_CYC(50), .FAN_DLY_CYC(20), .EIGHTH_CYC(16)) i_dut (
      .ref_clk_i, .srst_i, .cmd_valid_i, .cmd_type_i, .cmd_len_i, .cmd_data_i, .cmd_ready_o,
      .rsp_valid_o, .rsp_type_o, .rsp_len_o, .rsp_data_o, .power_pulse_cyc_i, .host_reset_o,
      .host_power_o, .self_reboot_o, .cursor_col_o, .cursor_row_o, .cursor_style_o, .contrast_o,
      .lcd_backlight_o, .key_backlight_o, .cell_o, .cell_idx_i, .fan_power_o, .fan_report_mask_o,
      .fan_report_o, .fan_report_idx_o);
   lmch_host_model i_host (.ref_clk_i, .cmd_valid_i, .cmd_type_i, .cmd_len_i, .cmd_data_i,
      .cmd_ready_o, .rsp_valid_o, .rsp_type_o, .rsp_len_o, .rsp_data_o);
   // 200 MHz clock and run ceiling
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         end_of_test;
      end
   end
   task end_of_test;
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [71:0] s, input logic [71:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task step;
      @(posedge ref_clk_i);
      #1;
   endtask
   // send a packet and judge the answer type
   task tx(input [7:0] t, input [4:0] l, input [71:0] d, input [7:0] et);
      i_host.send(t, l, d);
      chk("answered", i_host.got, 1'b1);
      chk("rsp_type", i_host.r_type, et);
   endtask
   task t_boot;
      int n;
      step;
      chk("fan_early", fan_power_o, 32'h0);
      for (n = 0; n < 300 && cmd_ready_o !== 1'b1; n++) step;
      chk("fan_full", fan_power_o, 32'h64646464);
      chk("cell0", cell_o, 8'h20);
   endtask
   task t_cursor;
      tx(8'h0b, 5'd2, 72'h0313, 8'h4b);
      chk("col_row", {cursor_col_o, cursor_row_o}, {5'd19, 2'd3});
      tx(8'h0b, 5'd2, 72'h0014, 8'hcb);
      chk("col_kept", cursor_col_o, 5'd19);
      for (int s = 0; s < 4; s++) begin
         tx(8'h0c, 5'd1, s, 8'h4c);
         chk("style", cursor_style_o, s[1:0]);
      end
      tx(8'h0c, 5'd1, 72'h04, 8'hcc);
      chk("style_kept", cursor_style_o, 2'd3);
      tx(8'h06, 5'd0, 72'h0, 8'h46);
      chk("home", {cursor_col_o, cursor_row_o}, 7'h0);
      cell_idx_i = 7'd79;
      #1 chk("cell79", cell_o, 8'h20);
   endtask
   task t_levels;
      tx(8'h0d, 5'd1, 72'hfe, 8'h4d);
      chk("contrast", contrast_o, 8'hfe);
      tx(8'h0d, 5'd1, 72'hff, 8'hcd);
      chk("contrast", contrast_o, 8'hfe);
      tx(8'h0e, 5'd1, 72'h32, 8'h4e);
      chk("lights", {lcd_backlight_o, key_backlight_o}, 16'h3232);
      tx(8'h0e, 5'd2, 72'h640a, 8'h4e);
      chk("lights", {lcd_backlight_o, key_backlight_o}, 16'h0a64);
      tx(8'h0e, 5'd1, 72'h65, 8'hce);
      chk("lights", {lcd_backlight_o, key_backlight_o}, 16'h0a64);
      tx(8'h01, 5'd0, 72'h0, 8'hc1);
   endtask
   task t_mem;
      tx(8'h09, 5'd9, 72'h070605040302013f01, 8'h49);
      tx(8'h09, 5'd9, 72'h08, 8'hc9);
      tx(8'h0a, 5'd1, 72'h48, 8'h4a);
      chk("glyph_len", i_host.r_len, 4'd9);
      chk("glyph", i_host.r_data, 72'h070605040302013f48);
      tx(8'h0a, 5'd1, 72'h80, 8'h4a);
      chk("row0", i_host.r_data, 72'h202020202020202080);
      for (int i = 0; i < 6; i++) begin
         tx(8'h0a, 5'd1, bad_a[i], 8'hca);
         chk("err_len", i_host.r_len, 4'd0);
         tx(8'h0a, 5'd1, good_a[i], 8'h4a);
      end
   endtask
   task t_fan;
      int n;
      tx(8'h11, 5'd4, 72'h281e140a, 8'h51);
      chk("fan_pwr", fan_power_o, 32'h281e140a);
      tx(8'h11, 5'd4, 72'h0a0a0a65, 8'hd1);
      chk("fan_kept", fan_power_o, 32'h281e140a);
      tx(8'h10, 5'd1, 72'h02, 8'h50);
      chk("mask", fan_report_mask_o, 4'h2);
      for (n = 0; n < 200 && fan_report_o !== 1'b1; n++) step;
      chk("rep_idx", fan_report_idx_o, 2'd1);
      chk("forced", fan_power_o[15:0], 16'h640a);
      step;
      for (n = 1; n < 200 && fan_report_o !== 1'b1; n++) step;
      chk("rep_gap", n, 64);
      tx(8'h10, 5'd1, 72'h10, 8'hd0);
      tx(8'h10, 5'd1, 72'h00, 8'h50);
   endtask
   task t_restart;
      int n;
      tx(8'h05, 5'd3, 72'h631208, 8'h45);
      for (n = 0; n < 20 && self_reboot_o !== 1'b1; n++) step;
      chk("reboot", self_reboot_o, 1'b1);
      tx(8'h05, 5'd3, 72'h030201, 8'hc5);
      chk("no_reset", {host_reset_o, host_power_o}, 2'b00);
      tx(8'h05, 5'd3, 72'h611c0c, 8'h45);
      chk("rst_on", {host_reset_o, cmd_ready_o}, 2'b10);
      for (n = 0; n < 300 && host_reset_o !== 1'b0; n++) step;
      chk("rst_len", n >= 45 && n <= 55, 1'b1);
      for (n = 0; n < 20 && self_reboot_o !== 1'b1; n++) step;
      chk("reboot", self_reboot_o, 1'b1);
      for (n = 0; n < 300 && cmd_ready_o !== 1'b1; n++) step;
      chk("mute_len", n >= 45 && n < 300, 1'b1);
      tx(8'h05, 5'd3, 72'h5f0b03, 8'h45);
      chk("pwr_on", host_power_o, 1'b1);
      for (n = 0; n < 100 && host_power_o !== 1'b0; n++) step;
      chk("pwr_len", n >= 7 && n <= 12, 1'b1);
   endtask
   // reset for two cycles, then the scenarios
   initial begin
      repeat (2) @(posedge ref_clk_i);
      #1;
      srst_i = 1'b0;
      t_boot;
      t_cursor;
      t_levels;
      t_mem;
      t_fan;
      t_restart;
      end_of_test;
   end
endmodule // lmch_cmd_handler_tb_top

// ==== tb/lmch_host_model.sv ====
// Purpose: host side of the command link
// Assumes: a packet is held on the lines until the handler is ready
// Notes: power control outputs are never driven from this side
`timescale 1ns/1ps
module lmch_host_model (
   // clock
   input  wire        ref_clk_i,
   // command packet out
   output reg         cmd_valid_i,
   output reg  [7:0]  cmd_type_i,
   output reg  [4:0]  cmd_len_i,
   output reg  [71:0] cmd_data_i,
   input  wire        cmd_ready_o,
   // response packet in
   input  wire        rsp_valid_o,
   input  wire [7:0]  rsp_type_o,
   input  wire [3:0]  rsp_len_o,
   input  wire [71:0] rsp_data_o
);
   reg        got;
   reg        rdy;
   reg [7:0]  r_type;
   reg [3:0]  r_len;
   reg [71:0] r_data;
   // lines idle low at start
   initial begin
      cmd_valid_i = 1'b0;
      cmd_type_i = 8'h00;
      cmd_len_i = 5'h00;
      cmd_data_i = 72'h0;
   end
   // hold one packet until taken, then grab the answer
   task send(input [7:0] t, input [4:0] l, input [71:0] d);
      integer n;
      begin
         got = 1'b0;
         n = 0;
         @(posedge ref_clk_i);
         #1;
         cmd_valid_i = 1'b1;
         cmd_type_i = t;
         cmd_len_i = l;
         cmd_data_i = d;
         do begin
            #3;
            rdy = cmd_ready_o;
            @(posedge ref_clk_i);
            n = n + 1;
         end while (rdy !== 1'b1 && n < 4000); // no answer expected while muted
         #1;
         cmd_valid_i = 1'b0;
         cmd_type_i = ~t;
         cmd_len_i = ~l;
         cmd_data_i = ~d;
         got = rsp_valid_o;
         r_type = rsp_type_o;
         r_len = rsp_len_o;
         r_data = rsp_data_o;
      end
   endtask
endmodule // lmch_host_model
